// *** src/balreg_pkg.sv ***
// shared constants and types for the balance result and identifier register block
package balreg_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0]  IDX_BALANCE_RESULT_CTRL = 8'h83;
	localparam logic [7:0]  IDX_UNIQUE_IDENT_LOW    = 8'h8c;
	localparam logic [7:0]  IDX_UNIQUE_IDENT_HIGH   = 8'h8d;
	localparam logic [7:0]  IDX_IRQ_STATUS          = 8'hf0;
	localparam logic [7:0]  IDX_IRQ_MASK            = 8'hf1;
	localparam logic [7:0]  IDX_SCAN_CONFIGURATION  = 8'hf2;
	localparam logic [11:0] ADDR_BALANCE_RESULT_CTRL = {2'b00, IDX_BALANCE_RESULT_CTRL, 2'b00};
	localparam logic [11:0] ADDR_UNIQUE_IDENT_LOW    = {2'b00, IDX_UNIQUE_IDENT_LOW, 2'b00};
	localparam logic [11:0] ADDR_UNIQUE_IDENT_HIGH   = {2'b00, IDX_UNIQUE_IDENT_HIGH, 2'b00};
	localparam logic [11:0] ADDR_IRQ_STATUS          = {2'b00, IDX_IRQ_STATUS, 2'b00};
	localparam logic [11:0] ADDR_IRQ_MASK            = {2'b00, IDX_IRQ_MASK, 2'b00};
	localparam logic [11:0] ADDR_SCAN_CONFIGURATION  = {2'b00, IDX_SCAN_CONFIGURATION, 2'b00};

	// field positions
	localparam int POS_STATE_HI   = 15;
	localparam int POS_STATE_LO   = 14;
	localparam int POS_READY      = 13;
	localparam int POS_STROBE     = 0;
	localparam int POS_SCAN_READY = 0;

	// balancing state codes
	localparam logic [1:0] BAL_DISABLED = 2'h0;
	localparam logic [1:0] BAL_ACTIVE   = 2'h1;
	localparam logic [1:0] BAL_DONE     = 2'h2;
	localparam logic [1:0] BAL_HALTED   = 2'h3;

	// balancing operating modes 000 disabled, 001 manual
	localparam logic [2:0] MODE_DISABLED = 3'h0;
	localparam logic [2:0] MODE_MANUAL   = 3'h1;

	// interrupt status bits
	localparam int IRQ_READY = 0;
	localparam int IRQ_DONE  = 1;
	localparam int IRQ_HALT  = 2;
	localparam int IRQ_W     = 3;

	// reset values
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK  = 3'h0;
	localparam logic [31:0]      IDENT_DEFAULT = 32'h5a3c_0f01; // arbitrary value

	// cycles the transfer engine needs to copy the results
	localparam logic [2:0] XFER_CYCLES = 3'h4;

	// transfer engine states
	typedef enum logic [1:0] {XF_IDLE, XF_COPY, XF_DONE} xfer_state_t;

endpackage : balreg_pkg

// *** src/ident_rom.sv ***
// read-only unique identifier store with checksum contribution
`timescale 1ns/100ps
`default_nettype none
module ident_rom
	import balreg_pkg::*;
#(
	parameter logic [31:0] IDENT = IDENT_DEFAULT
) (
	output logic [15:0] ident_low,
	output logic [15:0] ident_high,
	output logic [7:0]  ident_check
);
	// low word carries bit 0 forced high so even a blank part reads one
	assign ident_low   = {IDENT[15:1], 1'b1}; // R11 R13
	assign ident_high  = {IDENT[31:24], 8'h00}; // R12
	// byte-wise xor folded into the rom check code
	assign ident_check = IDENT[7:0] ^ IDENT[15:8] ^ IDENT[23:16] ^ IDENT[31:24]; // R15
endmodule : ident_rom
`default_nettype wire

// *** src/xfer_engine.sv ***
// copies filtered results into data registers on request
`timescale 1ns/100ps
`default_nettype none
module xfer_engine
	import balreg_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	typedef struct packed {
		xfer_state_t state;
		logic [2:0]  cnt;
		logic        done;
	} xf_t;
	xf_t q_reg, q_next;

	// sequencer: idle, copy for a fixed count, one done pulse
	always_comb begin
		q_next = q_reg;
		q_next.done = 1'b0;
		case (q_reg.state)
			XF_IDLE: begin
				if (start) begin
					q_next.state = XF_COPY;
					q_next.cnt = XFER_CYCLES;
				end
			end
			XF_COPY: begin
				// all result words copied in one atomic window
				if (q_reg.cnt == 3'h1) begin
					q_next.state = XF_DONE;
				end else begin
					q_next.cnt = q_reg.cnt - 3'h1;
				end
			end
			default: begin
				q_next.state = XF_IDLE;
				q_next.done = 1'b1; // R3 R8
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q_reg <= '{XF_IDLE, 3'h0, 1'b0};
		end else begin
			q_reg <= q_next;
		end
	end

	// busy only while copying, so the copy window spans exactly the copy count
	assign busy = (q_reg.state == XF_COPY);
	assign done = q_reg.done;
endmodule : xfer_engine
`default_nettype wire

// *** src/balance_result_regs.sv ***
// apb register bank: balance result control, identifier and interrupts
//
// Behaviour
// R1 - state mirror bits 15:14, 00/01/10 codes
// R2 - code 11 on abnormal balancing halt
// R3 - ready mirror bit 13 set on transfer
// R4 - writing zero clears ready mirror
// R5 - writing one to ready has no effect
// R6 - ready mirror equals scan config flag
// R7 - strobe bit 0 copies filtered results
// R8 - ready flag set when transfer completes
// R9 - strobe self-clears, always reads zero
// R10 - strobe ignored in manual/disabled or enable 0x
// R11 - low identifier register holds bits 15:0
// R12 - high identifier register holds bits 31:24
// R13 - low identifier bit 0 reads one
// R14 - host accepts identifier with two ones
// R15 - identifier in rom, in checksum
// R16 - undervolt stop flags held until restart; here also cleared while operating mode is disabled
// R17 - unused bits read zero, ignore writes
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module balance_result_regs
	import balreg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	// apb slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// balancing engine status, same clock
	input  wire logic        balance_active,
	input  wire logic        balance_done,
	input  wire logic        balance_thermal_alert,
	input  wire logic        balance_timeout_alert,
	input  wire logic        balance_calfault_alert,
	input  wire logic [2:0]  balance_operating_mode,
	input  wire logic [1:0]  balance_measure_enable,
	input  wire logic        balance_control_write,
	input  wire logic [13:0] balance_undervolt_hits,
	// results to the data path
	output logic             result_copy,
	output logic [13:0]      balance_undervolt_stop_flags,
	output logic [7:0]       rom_check_code,
	output logic             irq
);

	// whole module state in one struct
	typedef struct packed {
		logic [31:0]        rdata;
		logic               ready;
		logic               slverr;
		logic               ready_flag;
		logic               strobe;
		logic [1:0]         bal_state;
		logic [13:0]        uv_flags;
		logic [IRQ_W-1:0]   irq_stat;
		logic [IRQ_W-1:0]   irq_mask;
		logic               irq;
		logic               copy;
		logic [7:0]         check;
	} st_t;

	st_t s_reg;
	st_t s_next;

	logic [15:0] ident_low;   // identifier low word
	logic [15:0] ident_high;  // identifier high word
	logic [7:0]  ident_check; // identifier checksum share
	logic        xf_busy;     // transfer in progress
	logic        xf_done;     // transfer finished pulse
	logic        acc;         // apb access phase
	logic        wr;          // write takes effect
	logic        rd;          // read data taken
	logic        strobe_ok;   // strobe allowed in this mode
	logic        ready_set;   // hardware sets ready
	logic        halted;      // abnormal exit cause present

	// identifier rom
	ident_rom u_ident (
		.ident_low   (ident_low),
		.ident_high  (ident_high),
		.ident_check (ident_check)
	);

	// transfer sequencer, fed by the registered strobe pulse
	xfer_engine u_xfer (
		.clk   (clk),
		.rst_b (rst_b),
		.start (s_reg.strobe),
		.busy  (xf_busy),
		.done  (xf_done)
	);

	// one-wait apb: pready comes from a register in the second cycle of the access phase
	assign acc = psel && penable && !s_reg.ready;
	assign wr  = acc && pwrite;
	assign rd  = acc && !pwrite;

	// strobe only honoured in automated modes with measurement enabled
	assign strobe_ok = (balance_operating_mode != MODE_DISABLED) &&
		(balance_operating_mode != MODE_MANUAL) && balance_measure_enable[1]; // R10
	assign ready_set = xf_done; // R8
	assign halted = balance_thermal_alert || balance_timeout_alert || balance_calfault_alert;

	// next-state logic
	always_comb begin
		s_next = s_reg;
		s_next.ready = 1'b0;
		s_next.slverr = 1'b0;
		s_next.strobe = 1'b0; // R9
		s_next.copy = xf_busy;
		s_next.check = ident_check; // R15

		// balancing state mirror; halt takes priority over others
		if (halted) begin
			s_next.bal_state = BAL_HALTED; // R2
		end else if (balance_active) begin
			s_next.bal_state = BAL_ACTIVE; // R1
		end else if (balance_done) begin
			s_next.bal_state = BAL_DONE; // R1
		end else if (balance_operating_mode == MODE_DISABLED) begin
			s_next.bal_state = BAL_DISABLED; // R1
		end

		// stop flags stick until mode disabled or a new balancing start
		if (balance_control_write || balance_operating_mode == MODE_DISABLED) begin
			s_next.uv_flags = 14'h0000; // R16
		end else begin
			s_next.uv_flags = s_reg.uv_flags | balance_undervolt_hits; // R16
		end

		// apb access
		if (acc) begin
			s_next.ready = 1'b1;
			s_next.rdata = 32'h0000_0000; // R17
			if (paddr == ADDR_BALANCE_RESULT_CTRL) begin
				if (rd) begin
					// strobe bit always reads zero
					s_next.rdata[POS_STATE_HI:POS_STATE_LO] = s_reg.bal_state; // R1
					s_next.rdata[POS_READY] = s_reg.ready_flag; // R6
				end else begin
					// only writing zero clears; one has no effect
					if (pstrb[1] && !pwdata[POS_READY]) begin
						s_next.ready_flag = 1'b0; // R4 R5
					end
					if (pstrb[0] && pwdata[POS_STROBE] && strobe_ok && !xf_busy) begin
						s_next.strobe = 1'b1; // R7
					end
				end
			end else if (paddr == ADDR_SCAN_CONFIGURATION) begin
				// same flag seen through the scan configuration word
				if (rd) begin
					s_next.rdata[POS_SCAN_READY] = s_reg.ready_flag; // R6
				end else if (pstrb[0] && !pwdata[POS_SCAN_READY]) begin
					s_next.ready_flag = 1'b0; // R6
				end
			end else if (paddr == ADDR_UNIQUE_IDENT_LOW) begin
				if (rd) begin
					s_next.rdata[15:0] = ident_low; // R11 R13
				end
			end else if (paddr == ADDR_UNIQUE_IDENT_HIGH) begin
				if (rd) begin
					s_next.rdata[15:0] = ident_high; // R12
				end
			end else if (paddr == ADDR_IRQ_STATUS) begin
				if (rd) begin
					s_next.rdata[IRQ_W-1:0] = s_reg.irq_stat;
				end else if (pstrb[0]) begin
					s_next.irq_stat = s_reg.irq_stat & ~pwdata[IRQ_W-1:0];
				end
			end else if (paddr == ADDR_IRQ_MASK) begin
				if (rd) begin
					s_next.rdata[IRQ_W-1:0] = s_reg.irq_mask;
				end else if (pstrb[0]) begin
					s_next.irq_mask = pwdata[IRQ_W-1:0];
				end
			end else begin
				// unmapped address: error answer, no effect
				s_next.slverr = 1'b1;
			end
		end

		// hardware sets win over software clears in the same cycle
		if (ready_set) begin
			s_next.ready_flag = 1'b1; // R3 R8
			s_next.irq_stat[IRQ_READY] = 1'b1;
		end
		if (s_next.bal_state == BAL_DONE && s_reg.bal_state != BAL_DONE) begin
			s_next.irq_stat[IRQ_DONE] = 1'b1;
		end
		if (s_next.bal_state == BAL_HALTED && s_reg.bal_state != BAL_HALTED) begin
			s_next.irq_stat[IRQ_HALT] = 1'b1;
		end
		s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '{32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0, BAL_DISABLED, 14'h0000,
				3'h0, RST_IRQ_MASK, 1'b0, 1'b0, 8'h00};
		end else begin
			s_reg <= s_next;
		end
	end

	// all outputs straight from flip-flops
	assign prdata  = s_reg.rdata;
	assign pready  = s_reg.ready;
	assign pslverr = s_reg.slverr;
	assign result_copy = s_reg.copy; // R3
	assign balance_undervolt_stop_flags = s_reg.uv_flags;
	assign rom_check_code = s_reg.check;
	assign irq = s_reg.irq;

endmodule : balance_result_regs
`default_nettype wire

// *** tb/balreg_monitor.sv ***
// concurrent checks on the ports of the balance result register bank
`timescale 1ns/100ps
`default_nettype none
module balreg_monitor
	import balreg_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        balance_thermal_alert,
	input wire logic        balance_timeout_alert,
	input wire logic        balance_calfault_alert,
	input wire logic [2:0]  balance_operating_mode,
	input wire logic [1:0]  balance_measure_enable,
	input wire logic        balance_control_write,
	input wire logic [13:0] balance_undervolt_hits,
	input wire logic        result_copy,
	input wire logic [13:0] balance_undervolt_stop_flags
);
	// strobe write at its taking edge; a busy engine would refuse it, so idle only
	wire logic stb = psel && penable && !pready && pwrite && paddr == ADDR_BALANCE_RESULT_CTRL && pwdata[0] && !result_copy;
	wire logic ok  = balance_operating_mode > MODE_MANUAL && balance_measure_enable[1]; // mode and enable allow
	wire logic rd  = pready && !pwrite && !pslverr; // completed read
	wire logic al  = balance_thermal_alert || balance_timeout_alert || balance_calfault_alert;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_copy_len: assert property ($rose(result_copy) |-> result_copy[*4] ##1 !result_copy)
		else $error("copy window not four cycles");
	a_strobe_go: assert property (stb && ok |-> ##[1:4] result_copy)
		else $error("accepted strobe did not start a copy");
	a_strobe_ign: assert property (stb && !ok |=> !result_copy[*6])
		else $error("refused strobe started a copy");
	a_ctrl_zero: assert property (rd && paddr == ADDR_BALANCE_RESULT_CTRL |-> prdata[31:16] == 0 && prdata[12:0] == 0)
		else $error("control read shows strobe or unused bits");
	a_ident_low: assert property (rd && paddr == ADDR_UNIQUE_IDENT_LOW |-> prdata[0] && prdata[31:16] == 0)
		else $error("low identifier bit zero not one");
	a_ident_high: assert property (rd && paddr == ADDR_UNIQUE_IDENT_HIGH |-> prdata[15:8] == IDENT_DEFAULT[31:24])
		else $error("high identifier byte wrong");
	a_map_ok: assert property (pready && (paddr == ADDR_BALANCE_RESULT_CTRL || paddr == ADDR_UNIQUE_IDENT_LOW) |-> !pslverr)
		else $error("mapped access flagged as error");
	a_state_halt: assert property (rd && paddr == ADDR_BALANCE_RESULT_CTRL && $past(al) && $past(al, 2) && $past(al, 3)
		|-> prdata[15:14] == BAL_HALTED)
		else $error("halt code missing during alert");
	a_stop_sticky: assert property (!balance_control_write && balance_operating_mode != MODE_DISABLED
		|=> (balance_undervolt_stop_flags & $past(balance_undervolt_stop_flags | balance_undervolt_hits))
		== $past(balance_undervolt_stop_flags | balance_undervolt_hits))
		else $error("stop flag lost without restart");
endmodule : balreg_monitor
bind balance_result_regs balreg_monitor mon_u (.*);
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the balance result register bank
`timescale 1ns/100ps
`default_nettype none
module tb
	import balreg_pkg::*;
;
	localparam logic [32:0] FULL = 33'h1_ffff_ffff; // compare every bit and the error flag
	localparam logic [11:0] CTRL = ADDR_BALANCE_RESULT_CTRL;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, d;
	logic [3:0] pstrb = 4'hf; // full words only
	logic pready, pslverr, result_copy, irq;
	logic balance_active = 0, balance_done = 0, balance_thermal_alert = 0;
	logic balance_timeout_alert = 0, balance_calfault_alert = 0, balance_control_write = 0;
	logic [2:0] balance_operating_mode = 0;
	logic [1:0] balance_measure_enable = 0;
	logic [13:0] balance_undervolt_hits = 0, balance_undervolt_stop_flags, acc;
	logic [7:0] rom_check_code;
	logic [65:0] q[$], e; // expected notes: {mask, error and data}
	logic [4:0] st [6] = '{5'h00, 5'h10, 5'h08, 5'h1c, 5'h02, 5'h01}; // active done thermal timeout calfault
	logic [1:0] ex [6] = '{BAL_DISABLED, BAL_ACTIVE, BAL_DONE, BAL_HALTED, BAL_HALTED, BAL_HALTED};
	int mismatches = 0, checked = 0, seed = 32'h4f8a_7808;
	balance_result_regs dut_u (.*);
	// free running clock
	always #5 clk = ~clk;
	task close_out;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task chk(input logic [32:0] got, input logic [32:0] exp, input logic [32:0] m);
		checked++;
		if ((got & m) !== (exp & m)) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got & m, exp & m);
		end
	endtask : chk
	// one apb transfer; request held until pready is sampled high, then an idle edge
	task xf(input logic w, input logic [11:0] a, input logic [31:0] dt, input logic [32:0] x, input logic [32:0] m);
		q.push_back({m, x});
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : xf
	task wr(input logic [11:0] a, input logic [31:0] dt);
		xf(1, a, dt, 33'h0_0000_0000, 33'h1_0000_0000);
	endtask : wr
	task rd(input logic [11:0] a, input logic [31:0] x, input logic [32:0] m);
		xf(0, a, 32'h0000_0000, {1'b0, x}, m);
	endtask : rd
	// answer watcher: oldest note is compared whenever pready shows
	always @(posedge clk) begin
		if (pready === 1'b1) begin
			e = q.pop_front();
			chk({pslverr, prdata}, e[32:0], e[65:33]);
		end
	end
	// hang guard, well beyond the few hundred cycles the sequence needs
	initial begin
		#200000;
		mismatches++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_b <= 1;
		@(posedge clk);
		rd(CTRL, 32'h0000_0000, FULL);
		xf(0, 12'h100, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000);
		rd(ADDR_UNIQUE_IDENT_LOW, {16'h0000, IDENT_DEFAULT[15:1], 1'b1}, FULL);
		wr(ADDR_UNIQUE_IDENT_HIGH, $random(seed));
		rd(ADDR_UNIQUE_IDENT_HIGH, {16'h0000, IDENT_DEFAULT[31:24], 8'h00}, FULL);
		chk({32'h0, $countones(IDENT_DEFAULT) >= 2}, 33'h1, 33'h1);
		chk({25'h0, rom_check_code}, {25'h0, IDENT_DEFAULT[31:24] ^ IDENT_DEFAULT[23:16]
			^ IDENT_DEFAULT[15:8] ^ IDENT_DEFAULT[7:0]}, FULL);
		wr(ADDR_IRQ_MASK, 32'h0000_0001);
		// refused strobes: disabled, manual, enable 0x
		for (int i = 0; i < 3; i++) begin
			balance_operating_mode <= i == 0 ? MODE_DISABLED : i == 1 ? MODE_MANUAL : 3'h2;
			balance_measure_enable <= i == 2 ? 2'b01 : 2'b10;
			wr(CTRL, 32'h0000_0001);
			repeat (8) @(posedge clk);
			rd(CTRL, 32'h0000_0000, 33'h0_0000_2001);
		end
		balance_measure_enable <= 2'b11;
		balance_active <= 1;
		d = $random(seed);
		wr(CTRL, (d | 32'h0000_2000) & 32'hffff_fffe);
		rd(CTRL, 32'h0000_4000, FULL);
		wr(CTRL, 32'h0000_0001);
		repeat (8) @(posedge clk);
		rd(CTRL, 32'h0000_6000, FULL);
		wr(CTRL, 32'h0000_2000);
		chk({32'h0, irq}, 33'h1, 33'h1);
		rd(ADDR_SCAN_CONFIGURATION, 32'h0000_0001, 33'h0_0000_0001);
		wr(CTRL, 32'h0000_0000);
		rd(CTRL, 32'h0000_4000, FULL);
		rd(ADDR_SCAN_CONFIGURATION, 32'h0000_0000, 33'h0_0000_0001);
		wr(ADDR_IRQ_STATUS, 32'h0000_0001);
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		wr(CTRL, 32'h0000_0001);
		repeat (8) @(posedge clk);
		chk({32'h0, irq}, 33'h0, 33'h1);
		rd(ADDR_IRQ_STATUS, 32'h0000_0001, 33'h0_0000_0001);
		wr(ADDR_SCAN_CONFIGURATION, 32'h0000_0000);
		rd(CTRL, 32'h0000_4000, FULL);
		// every balancing state code, halt winning over active and done
		for (int i = 0; i < 6; i++) begin
			{balance_active, balance_done, balance_thermal_alert, balance_timeout_alert, balance_calfault_alert} <= st[i];
			balance_operating_mode <= i == 0 ? MODE_DISABLED : 3'h2;
			repeat (3) @(posedge clk);
			rd(CTRL, {16'h0000, ex[i], 14'h0000}, 33'h0_0000_c000);
		end
		// sticky stop flags accumulate until a restart write
		acc = 0;
		for (int i = 0; i < 2; i++) begin
			d = $random(seed);
			acc = acc | d[13:0];
			balance_undervolt_hits <= d[13:0];
			@(posedge clk);
			balance_undervolt_hits <= 0;
			repeat (3) @(posedge clk);
			chk({19'h0, balance_undervolt_stop_flags}, {19'h0, acc}, FULL);
		end
		balance_control_write <= 1;
		@(posedge clk);
		balance_control_write <= 0;
		repeat (3) @(posedge clk);
		chk({19'h0, balance_undervolt_stop_flags}, 33'h0, FULL);
		close_out();
	end
endmodule : tb
`default_nettype wire
